// ==== verilog/reset_source_controller.sv ====
// Purpose: Gathers reset sources, steers core/TAP/peripheral resets,
//          sequences the vector fetch and keeps the reset cause register.
// Assumes: srst_i models the supply-level power-up; por_i is the detector.
// Notes:   Fetch handshake with the core uses fetch_ack_i per step.
// Summary of operation
// - Six reset sources each may start a reset sequence.
// - Power-on resets core, every peripheral and the test access port.
// - External pin resets core and peripherals; TAP only pin config.
// - Brown-out, software, watchdog, oscillator reset core, peripherals, TAP pin config.
// - Software peripheral reset touches only the selected peripherals.
// - Software system reset fires on the system reset request bit.
// - After a reset the matching cause bit is set.
// - Cause bits stay sticky across resets other than power-on.
// - Hold reset until power-on detector goes inactive, then fetch.
// - On release fetch stack pointer, then counter, then instruction.
// - Power-on detector is honoured only during initial power-up.
// - NMI pin is plain GPIO until commit-protected select bit is set.
// - Peripheral resets when its bit is set and then cleared.
// - Brown-out resets only when enabled; held while supply is low.
// - Watchdog resets on second unserviced time-out, if enabled.
// - Oscillator failure reset recorded in its own cause flag.
`default_nettype none
module reset_source_controller
    import rst_ctrl_pkg::*;
#(
    parameter int unsigned PERIPHS = rst_ctrl_pkg::NUM_PERIPH
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // Reset sources
    input  wire logic                 rst_n_i,
    input  wire logic                 por_i,
    input  wire logic                 brownout_i,
    input  wire logic                 brownout_reset_enable_i,
    input  wire logic                 system_reset_request_bit_i,
    input  wire logic                 wdt_timeout_i,
    input  wire logic                 wdt_service_i,
    input  wire logic                 wdt_reset_enable_i,
    input  wire logic                 osc_fail_i,
    // Software peripheral reset bits and cause clear
    input  wire logic [PERIPHS-1:0]   peripheral_reset_regs_i,
    input  wire logic [5:0]           cause_clear_i,
    // NMI pin configuration
    input  wire logic                 nmi_pin_i,
    input  wire logic                 alt_function_bit_i,
    input  wire logic                 commit_i,
    // Core vector fetch handshake
    input  wire logic                 fetch_ack_i,
    output logic                      fetch_sp_o,
    output logic                      fetch_pc_o,
    output logic                      fetch_insn_o,
    output logic                      core_run_o,
    // Reset outputs
    output logic                      core_rst_o,
    output logic                      tap_rst_o,
    output logic                      tap_pin_cfg_rst_o,
    output logic [PERIPHS-1:0]        periph_rst_o,
    // NMI and status
    output logic                      nmi_o,
    output logic                      gpio_b7_o,
    output logic [5:0]                reset_cause_register_o
);
    import rst_ctrl_pkg::*;

    logic               pin_low_s;
    logic               por_s;
    logic               bor_s;
    logic               sw_s;
    logic               wdt_to_s;
    logic               osc_s;
    logic [CNT_W-1:0]   pin_cnt_q;
    logic               por_seen_q;
    logic               wdt_armed_q;
    logic               wdt_fire_q;
    logic               sys_seen_q;
    logic [5:0]         cause_q;
    logic [5:0]         cause_d;
    logic [5:0]         pend_q;
    logic [CNT_W-1:0]   hold_q;
    logic               tap_q;
    logic               nmi_sel_q;
    seq_state_t         state_q;
    seq_state_t         state_d;
    logic [PERIPHS-1:0] sw_prev_q;
    logic [PERIPHS-1:0] periph_pulse_q;

    // Every source passes a two-flop stage before it can touch reset
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b1)) u_pin (
        .clk_i(clk_i), .srst_i(srst_i), .d_i(~rst_n_i), .q_o(pin_low_s));
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b1)) u_por (
        .clk_i(clk_i), .srst_i(srst_i), .d_i(por_i), .q_o(por_s));
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b0)) u_bor (
        .clk_i(clk_i), .srst_i(srst_i), .d_i(brownout_i), .q_o(bor_s));
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b0)) u_sw (
        .clk_i(clk_i), .srst_i(srst_i),
        .d_i(system_reset_request_bit_i), .q_o(sw_s));
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b0)) u_wdt (
        .clk_i(clk_i), .srst_i(srst_i), .d_i(wdt_timeout_i), .q_o(wdt_to_s));
    rst_sync #(.STAGES(SYNC_STAGES), .INIT(1'b0)) u_osc (
        .clk_i(clk_i), .srst_i(srst_i), .d_i(osc_fail_i), .q_o(osc_s));

    // Short pin glitches are filtered; the board owns the minimum width
    wire pin_req  = pin_low_s && (pin_cnt_q >= CNT_W'(PIN_MIN_CYC));
    // Detector only counts until it has gone quiet once after power-up
    wire por_req  = por_s && !por_seen_q;
    wire bor_req  = bor_s && brownout_reset_enable_i;
    wire sw_req   = sw_s && !sys_seen_q;
    wire wdt_req  = wdt_fire_q;
    wire osc_req  = osc_s;
    wire [5:0] src_vec = {osc_req, wdt_req, sw_req,
                          bor_req, por_req, pin_req};
    wire any_req  = |src_vec;
    wire wdt_tick = wdt_to_s && !wdt_fire_q;
    wire in_reset = (state_q == ST_HOLD);

    always_ff @(posedge clk_i)
    begin
        if (srst_i || !pin_low_s)
            pin_cnt_q <= '0;
        else if (pin_cnt_q != {CNT_W{1'b1}})
            pin_cnt_q <= pin_cnt_q + CNT_W'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            por_seen_q <= 1'b0;
        else if (!por_s)
            por_seen_q <= 1'b1;
    end

    // First time-out arms, second unserviced one fires
    always_ff @(posedge clk_i)
    begin
        if (srst_i || wdt_service_i || in_reset)
        begin
            wdt_armed_q <= 1'b0;
            wdt_fire_q  <= 1'b0;
        end
        else if (wdt_tick)
        begin
            wdt_armed_q <= 1'b1;
            wdt_fire_q  <= wdt_armed_q && wdt_reset_enable_i;
        end
    end

    // Request bit is level; one reset per assertion avoids a reset loop
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !sw_s)
            sys_seen_q <= 1'b0;
        else if (in_reset)
            sys_seen_q <= 1'b1;
    end

    // Sequencer: hold, short release delay, three fetch steps, run
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_HOLD:       if (!any_req) state_d = ST_RELEASE;
            ST_RELEASE:    if (hold_q == '0) state_d = ST_FETCH_SP;
            ST_FETCH_SP:   if (fetch_ack_i) state_d = ST_FETCH_PC;
            ST_FETCH_PC:   if (fetch_ack_i) state_d = ST_FETCH_INSN;
            ST_FETCH_INSN: if (fetch_ack_i) state_d = ST_RUN;
            ST_RUN:        state_d = ST_RUN;
            default:       state_d = ST_HOLD;
        endcase
        if (any_req)
            state_d = ST_HOLD;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            state_q <= ST_HOLD;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || state_q != ST_RELEASE)
            hold_q <= CNT_W'(HOLD_CYC);
        else if (hold_q != '0)
            hold_q <= hold_q - CNT_W'(1);
    end

    // Pending causes latch while holding and land in the register at release
    always_ff @(posedge clk_i)
    begin
        if (srst_i || state_q == ST_RELEASE)
            pend_q <= '0;
        else
            pend_q <= pend_q | src_vec;
    end

    // Power-on wipes the other causes; otherwise bits only accumulate.
    // A cause landing in a clear cycle survives the clear.
    always_comb
    begin
        cause_d = cause_q & ~cause_clear_i;
        if (state_q == ST_RELEASE && hold_q == CNT_W'(HOLD_CYC))
        begin
            if (pend_q[CAUSE_POR])
                cause_d = CAUSE_RESET;
            else
                cause_d = cause_d | pend_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cause_q <= CAUSE_RESET;
        else
            cause_q <= cause_d;
    end

    // TAP follows only power-on; pin reset touches its pin config only
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            tap_q <= 1'b1;
        else
            tap_q <= por_req;
    end

    // Commit-protected select for the NMI function; power-on returns GPIO
    always_ff @(posedge clk_i)
    begin
        if (srst_i || (in_reset && por_req))
            nmi_sel_q <= 1'b0;
        else if (commit_i)
            nmi_sel_q <= alt_function_bit_i;
    end

    // Each peripheral gets a one-cycle reset on the falling edge of its bit
    genvar g;
    generate
        for (g = 0; g < PERIPHS; g++)
        begin : g_per
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    sw_prev_q[g]      <= 1'b0;
                    periph_pulse_q[g] <= 1'b0;
                end
                else
                begin
                    sw_prev_q[g]      <= peripheral_reset_regs_i[g];
                    periph_pulse_q[g] <= sw_prev_q[g] &&
                                         !peripheral_reset_regs_i[g];
                end
            end
        end
    endgenerate

    assign core_rst_o        = (state_q != ST_RUN) &&
                               (state_q != ST_FETCH_SP) &&
                               (state_q != ST_FETCH_PC) &&
                               (state_q != ST_FETCH_INSN);
    assign tap_rst_o         = tap_q;
    assign tap_pin_cfg_rst_o = in_reset;
    assign periph_rst_o      = {PERIPHS{core_rst_o}} |
                               periph_pulse_q;
    assign fetch_sp_o        = (state_q == ST_FETCH_SP);
    assign fetch_pc_o        = (state_q == ST_FETCH_PC);
    assign fetch_insn_o      = (state_q == ST_FETCH_INSN);
    assign core_run_o        = (state_q == ST_RUN);
    assign nmi_o             = nmi_sel_q && nmi_pin_i;
    assign gpio_b7_o         = !nmi_sel_q && nmi_pin_i;
    assign reset_cause_register_o = cause_q;
endmodule
`default_nettype wire

// ==== shared/rst_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the reset source controller.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes:   Cause bit positions are the layout of the reset cause register.
`default_nettype none
package rst_ctrl_pkg;

    localparam int unsigned NUM_SOURCES    = 6;
    localparam int unsigned CAUSE_EXT      = 0;
    localparam int unsigned CAUSE_POR      = 1;
    localparam int unsigned CAUSE_BOR      = 2;
    localparam int unsigned CAUSE_SW       = 3;
    localparam int unsigned CAUSE_WDT      = 4;
    localparam int unsigned CAUSE_OSC      = 5;
    localparam logic [5:0]  CAUSE_RESET    = 6'h02;
    localparam int unsigned NUM_PERIPH     = 8;
    localparam int unsigned SYNC_STAGES    = 2;
    // Minimum external pin low time accepted as a reset, in ns
    localparam int unsigned CLK_MHZ        = 25;
    localparam int unsigned PIN_MIN_NS     = 400;
    localparam int unsigned PIN_MIN_CYC    =
        (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
    // Hold of internal reset after all sources go quiet, in ns
    localparam int unsigned HOLD_NS        = 200;
    localparam int unsigned HOLD_CYC       =
        (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W          = 8;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_RELEASE,
        ST_FETCH_SP,
        ST_FETCH_PC,
        ST_FETCH_INSN,
        ST_RUN
    } seq_state_t;

endpackage
`default_nettype wire

// ==== verilog/rst_sync.sv ====
// Purpose: Two-flop synchroniser for one level.
// Assumes: Input may change at any time relative to clk_i.
// Notes:   First stage feeds only the second stage.
`default_nettype none
module rst_sync #(
    parameter int unsigned STAGES = 2,
    parameter logic        INIT   = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Level
    input  wire logic d_i,
    output logic      q_o
);
    logic [STAGES-1:0] sync_q;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sync_q <= {STAGES{INIT}};
        else
            sync_q <= {sync_q[STAGES-2:0], d_i};
    end

    assign q_o = sync_q[STAGES-1];
endmodule
`default_nettype wire

// ==== verification/reset_source_controller_chk.sv ====
// Purpose: Port-level checks for the reset source controller.
// Assumes: One clock; srst_i synchronous, active high.
// Notes:   Fetch steps are tied to the ack that ends each step.
`default_nettype none
module reset_source_controller_chk
    import rst_ctrl_pkg::*;
#(
    parameter int unsigned PERIPHS = 8
) (
    // Clock, reset and inputs
    input wire logic               clk_i,
    input wire logic               srst_i,
    input wire logic               por_i,
    input wire logic               fetch_ack_i,
    input wire logic [5:0]         cause_clear_i,
    // Outputs
    input wire logic               fetch_sp_o,
    input wire logic               fetch_pc_o,
    input wire logic               fetch_insn_o,
    input wire logic               core_run_o,
    input wire logic               core_rst_o,
    input wire logic               tap_rst_o,
    input wire logic [PERIPHS-1:0] periph_rst_o,
    input wire logic [5:0]         reset_cause_register_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence sp_taken;
        fetch_sp_o && fetch_ack_i;
    endsequence
    sequence pc_taken;
        fetch_pc_o && fetch_ack_i;
    endsequence
    sequence insn_taken;
        fetch_insn_o && fetch_ack_i;
    endsequence

    a_power_up_cause: assert property ($fell(srst_i) |-> core_rst_o
        && tap_rst_o && reset_cause_register_o == CAUSE_RESET)
        else $error("power-up state wrong");
    a_sp_then_pc: assert property (sp_taken |=> fetch_pc_o)
        else $error("counter fetch did not follow");
    a_pc_then_insn: assert property (pc_taken |=> fetch_insn_o)
        else $error("instruction fetch did not follow");
    a_insn_then_run: assert property (insn_taken |=>
        core_run_o && !core_rst_o) else $error("core did not start");
    a_fetch_one_step: assert property ($onehot0({fetch_sp_o,
        fetch_pc_o, fetch_insn_o, core_run_o}))
        else $error("fetch steps overlap");
    a_tap_spared: assert property ((!por_i) [*4] |-> !tap_rst_o)
        else $error("tap reset without power-on");
    a_core_with_periph: assert property (core_rst_o |->
        periph_rst_o == {PERIPHS{1'b1}})
        else $error("peripherals not reset with core");
    // Two quiet cycles allow for a registered clear
    a_cause_sticky: assert property ((cause_clear_i == 6'h00) [*2] |=>
        (reset_cause_register_o & $past(reset_cause_register_o))
        == $past(reset_cause_register_o))
        else $error("cause bit dropped");
endmodule

bind reset_source_controller reset_source_controller_chk #(
    .PERIPHS(PERIPHS)
) chk_inst (
    .clk_i(clk_i), .srst_i(srst_i), .por_i(por_i),
    .fetch_ack_i(fetch_ack_i), .cause_clear_i(cause_clear_i),
    .fetch_sp_o(fetch_sp_o), .fetch_pc_o(fetch_pc_o),
    .fetch_insn_o(fetch_insn_o), .core_run_o(core_run_o),
    .core_rst_o(core_rst_o), .tap_rst_o(tap_rst_o),
    .periph_rst_o(periph_rst_o),
    .reset_cause_register_o(reset_cause_register_o)
);
`default_nettype wire

// ==== verification/board_reset_model.sv ====
// Purpose: Board reset circuit driving the active-low reset pin.
// Assumes: Pin has a pull-up, so released means high.
// Notes:   Short presses are legal stimulus for glitch checks.
`default_nettype none
module board_reset_model (
    // Clock
    input wire logic clk_i,
    // Reset pin
    output var logic rst_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rst_n_o = 1'b1;
    // Low for n cycles, then the pull-up takes over
    task automatic press(input int n);
        @(negedge clk_i);
        rst_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        rst_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== verification/reset_source_controller_test.sv ====
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Inputs change on falling edges only.
// Notes:   Cause bits accumulate across the source loop.
`default_nettype none
module reset_source_controller_test import rst_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, rst_n, por, bor, bor_en, sysreq, wdt_to, wdt_svc;
    logic wdt_en, osc, nmi_pin, alt, commit, ack, sp, pc, insn, run;
    logic core_rst, tap_rst, tap_cfg, nmi, gpio;
    logic [7:0] preg, prst, acc;
    logic [5:0] cclr, cause, exp;
    int error_cnt = 0, n_compared = 0, k;
    int unsigned pos[5] = '{CAUSE_EXT, CAUSE_BOR, CAUSE_SW, CAUSE_OSC,
                            CAUSE_WDT};

    board_reset_model board_reset_model_inst (.clk_i(clk), .rst_n_o(rst_n));
    reset_source_controller #(.PERIPHS(8)) reset_source_controller_inst (
        .clk_i(clk), .srst_i(srst), .rst_n_i(rst_n), .por_i(por),
        .brownout_i(bor), .brownout_reset_enable_i(bor_en),
        .system_reset_request_bit_i(sysreq), .wdt_timeout_i(wdt_to),
        .wdt_service_i(wdt_svc), .wdt_reset_enable_i(wdt_en),
        .osc_fail_i(osc), .peripheral_reset_regs_i(preg),
        .cause_clear_i(cclr), .nmi_pin_i(nmi_pin),
        .alt_function_bit_i(alt), .commit_i(commit), .fetch_ack_i(ack),
        .fetch_sp_o(sp), .fetch_pc_o(pc), .fetch_insn_o(insn),
        .core_run_o(run), .core_rst_o(core_rst), .tap_rst_o(tap_rst),
        .tap_pin_cfg_rst_o(tap_cfg), .periph_rst_o(prst), .nmi_o(nmi),
        .gpio_b7_o(gpio), .reset_cause_register_o(cause));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tick(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask

    // Core must stay out of reset; also gathers peripheral pulses
    task automatic quiet(input string what);
        acc = 8'h00;
        repeat (15)
        begin
            @(negedge clk);
            acc |= prst;
            chk(what, 8'h00, {7'h00, core_rst});
        end
    endtask

    // Vector fetch handshake, one ack per step; bounded waits
    task automatic boot();
        int s, j;
        for (s = 0; s < 3; s++)
        begin
            for (j = 0; j < 40 && {sp, pc, insn} == 3'b000; j++)
                @(negedge clk);
            chk("fetch step", 8'(3'b100 >> s), {5'h00, sp, pc, insn});
            if (j == 40)
                end_of_test();
            ack = 1'b1;
            @(negedge clk);
            ack = 1'b0;
            // An idle edge keeps ack from falling and rising in one step
            @(negedge clk);
        end
        chk("core run", 8'h01, {7'h00, run});
    endtask

    initial
    begin
        {srst, por, bor, bor_en, sysreq, wdt_to, wdt_svc} = 7'h60;
        {wdt_en, osc, nmi_pin, alt, commit, ack} = 6'h20;
        preg = 8'h00;
        cclr = 6'h00;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk("tap at power-up", 8'h01, {7'h00, tap_rst});
        por = 1'b0;
        boot();
        chk("cause power-up", 8'h02, {2'h0, cause});
        $display("power-up test done");
        bor = 1'b1;
        quiet("brown-out disabled");
        bor = 1'b0;
        board_reset_model_inst.press(3);
        quiet("short pin");
        tick(wdt_to);
        tick(wdt_svc);
        tick(wdt_to);
        quiet("single wdt tick");
        tick(wdt_svc);
        wdt_en = 1'b0;
        tick(wdt_to);
        tick(wdt_to);
        quiet("wdt reset disabled");
        tick(wdt_svc);
        wdt_en = 1'b1;
        $display("refusal test done");
        preg = 8'h5A;
        repeat (2) @(negedge clk);
        preg = 8'h00;
        quiet("core in periph reset");
        chk("periph pulses", 8'h5A, acc);
        $display("peripheral test done");
        nmi_pin = 1'b1;
        alt = 1'b1;
        @(negedge clk);
        chk("nmi before commit", 8'h01, {6'h00, nmi, gpio});
        tick(commit);
        chk("nmi after commit", 8'h01, {7'h00, nmi});
        $display("nmi test done");
        bor_en = 1'b1;
        exp = CAUSE_RESET;
        // Checks fall while the internal reset still stands
        for (k = 0; k < 5; k++)
        begin
            if (k == 0)
                board_reset_model_inst.press(14);
            else if (k == 4)
            begin
                tick(wdt_to);
                tick(wdt_to);
                repeat (2) @(negedge clk);
            end
            else
            begin
                {osc, sysreq, bor} = 3'(1 << (k - 1));
                repeat (4) @(negedge clk);
            end
            chk("core reset", 8'h01, {7'h00, core_rst});
            chk("tap reset", 8'h00, {7'h00, tap_rst});
            chk("periph reset", 8'hFF, prst);
            if (k == 0)
                chk("tap pin config", 8'h01, {7'h00, tap_cfg});
            {osc, sysreq, bor} = 3'b000;
            boot();
            exp |= 6'(1 << pos[k]);
            chk("cause", {2'h0, exp}, {2'h0, cause});
        end
        $display("source test done");
        cclr = 6'h3F;
        @(negedge clk);
        cclr = 6'h00;
        repeat (2) @(negedge clk);
        chk("cause cleared", 8'h00, {2'h0, cause});
        board_reset_model_inst.press(12);
        boot();
        chk("cause after clear", 8'h01, {2'h0, cause});
        $display("clear test done");
        end_of_test();
    end
endmodule
`default_nettype wire
